// ### include/iopb_cfg.svh
// iopb_cfg.svh: field positions, codes and reset values for the bus translator
// assumes inclusion by bare name from any design file
`ifndef IOPB_CFG_SVH
`define IOPB_CFG_SVH

// control field bit positions
`define IOPB_CTRL_W        7
`define IOPB_CTRL_ADDR_BIT 0
`define IOPB_CTRL_DATA_BIT 1
`define IOPB_CTRL_READ_BIT 2
`define IOPB_CTRL_BE_LSB   3
`define IOPB_CTRL_BE_W     4

// parity sense: 1 selects odd parity, 0 even
`define IOPB_PAR_ODD       1'b1

// processor transfer size codes
`define IOPB_SIZE_LONG     2'h0
`define IOPB_SIZE_BYTE     2'h1
`define IOPB_SIZE_WORD     2'h2
`define IOPB_SIZE_TRIPLE   2'h3

// function code that marks an access for the system bus
`define IOPB_FC_MATCH      2'h1

// reset values
`define IOPB_RST_DATA      32'h0000_0000
`define IOPB_RST_HALF      16'h0000
`define IOPB_RST_PAR       4'h0

`endif

// ### include/iopb_pkg.sv
// iopb_pkg: types and shared functions of the bus translator
// assumes iopb_cfg.svh on the include path
`default_nettype none
`include "iopb_cfg.svh"

package iopb_pkg;

    typedef enum logic [1:0] {
        IOPB_IDLE = 2'b00,
        IOPB_ADDR = 2'b01,
        IOPB_DATA = 2'b10,
        IOPB_WAIT = 2'b11
    } iopb_phase_t;

    // one parity bit per byte lane, lane 3 is bits 31:24
    function automatic logic [3:0] iopb_lane_parity(input logic [31:0] word);
        logic [3:0] p;
        p = 4'h0;
        for (int i = 0; i < 4; i++) begin
            p[i] = (^word[i*8 +: 8]) ^ `IOPB_PAR_ODD;
        end
        return p;
    endfunction : iopb_lane_parity

endpackage : iopb_pkg

`default_nettype wire

// ### verilog/iopb_arbiter.sv
// iopb_arbiter: requests and holds system bus tenure for processor accesses
// assumes inputs synchronous to core_clk; done and retry come from the controller
`default_nettype none
`include "iopb_cfg.svh"

module iopb_arbiter (
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    input  wire logic       top_address_bit,
    input  wire logic       function_code_hi,
    input  wire logic       function_code_lo,
    input  wire logic       processor_addr_strobe,
    input  wire logic       bus_grant_in,
    input  wire logic       bus_busy_line,
    input  wire logic       bus_lock,
    input  wire logic       retry_seen,
    input  wire logic       transaction_done,
    input  wire logic       bus_error_seen,
    output logic            bus_request_out,
    output logic            bus_ack_out,
    output logic            bus_tenure
);
    import iopb_pkg::*;

    logic req_r;
    logic req_nxt;
    logic ack_r;
    logic ack_nxt;

    always_comb begin
        req_nxt = top_address_bit && ({function_code_hi, function_code_lo} == `IOPB_FC_MATCH)
                  && processor_addr_strobe && !retry_seen && !bus_tenure && !transaction_done
                  && !ack_r && !bus_error_seen && !sys_rst;
        ack_nxt = (bus_grant_in && !bus_busy_line && !sys_rst)
                  || (ack_r && !transaction_done && !retry_seen && !sys_rst)
                  || (ack_r && bus_lock && !retry_seen && !sys_rst);
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            req_r <= 1'b0;
            ack_r <= 1'b0;
        end else begin
            req_r <= req_nxt;
            ack_r <= ack_nxt;
        end
    end

    assign bus_request_out = req_r;
    assign bus_ack_out     = ack_r;
    assign bus_tenure      = ack_r && !transaction_done && !retry_seen && !sys_rst;

endmodule : iopb_arbiter

`default_nettype wire

// ### verilog/iopb_parity.sv
// iopb_parity: lane parity generator and read-phase checker
// assumes the translator tells it the phase and the driven bus word
`default_nettype none
`include "iopb_cfg.svh"

module iopb_parity (
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic [31:0] bus_word_driven,
    input  wire logic [31:0] sys_ad_in,
    input  wire logic [3:0]  sys_par_in,
    input  wire logic        read_latch_en,
    output logic      [3:0]  par_gen,
    output logic             parity_fault
);
    import iopb_pkg::*;

    logic [31:0] lat_r;
    logic [31:0] lat_nxt;
    logic [3:0]  plat_r;
    logic [3:0]  plat_nxt;
    logic        chk_r;
    logic        chk_nxt;
    logic        fault_r;
    logic        fault_nxt;

    always_comb begin
        lat_nxt   = read_latch_en ? sys_ad_in : lat_r;
        plat_nxt  = read_latch_en ? sys_par_in : plat_r;
        chk_nxt   = read_latch_en;
        fault_nxt = chk_r && (iopb_lane_parity(lat_r) != plat_r);
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            lat_r   <= `IOPB_RST_DATA;
            plat_r  <= `IOPB_RST_PAR;
            chk_r   <= 1'b0;
            fault_r <= 1'b0;
        end else begin
            lat_r   <= lat_nxt;
            plat_r  <= plat_nxt;
            chk_r   <= chk_nxt;
            fault_r <= fault_nxt;
        end
    end

    // generated only from what stands on the multiplexed lines
    assign par_gen      = iopb_lane_parity(bus_word_driven);
    assign parity_fault = fault_r;

endmodule : iopb_parity

`default_nettype wire

// ### verilog/iopb_translator.sv
// iopb_translator: processor to multiplexed system bus translator, top level
// assumes all inputs synchronous to core_clk and the bench resolving the
// shared address/data and parity lines from the enables
`default_nettype none
`include "iopb_cfg.svh"

module iopb_translator #(
    parameter int AD_W      = 32,
    parameter int IOP_DW    = 16,
    parameter bit PARITY_EN = 1'b1
) (
    input  wire logic               core_clk,
    input  wire logic               sys_rst,
    input  wire logic [AD_W-1:0]    iop_addr,
    input  wire logic [IOP_DW-1:0]  iop_wdata,
    input  wire logic               iop_read,
    input  wire logic [1:0]         iop_size,
    input  wire logic               function_code_hi,
    input  wire logic               function_code_lo,
    input  wire logic               processor_addr_strobe,
    output logic      [IOP_DW-1:0]  iop_rdata,
    output logic                    iop_rdata_oe,
    output logic                    size_acknowledge,
    output logic                    bus_error_handshake,
    output logic                    halt_handshake,
    output logic                    bus_request_out,
    input  wire logic               bus_grant_in,
    input  wire logic               bus_busy_line,
    input  wire logic               bus_lock,
    output logic                    bus_ack_out,
    input  wire logic               status_eod,
    input  wire logic               status_wait,
    input  wire logic               status_retry,
    input  wire logic               status_error_line,
    input  wire logic [AD_W-1:0]    sys_ad_in,
    output logic      [AD_W-1:0]    sys_ad_out,
    output logic                    sys_ad_oe,
    input  wire logic [3:0]         sys_par_in,
    output logic      [3:0]         sys_par_out,
    output logic                    sys_par_oe,
    output logic      [`IOPB_CTRL_W-1:0] ctrl_out,
    output logic                    ctrl_par_out,
    output logic                    ctrl_oe,
    output logic                    address_phase_flag,
    output logic                    data_phase_flag,
    output logic                    read_latch_en,
    output logic                    bus_tenure,
    output logic                    transaction_done,
    output logic                    parity_fault
);
    import iopb_pkg::*;

    if (AD_W != 32 || IOP_DW * 2 != AD_W) begin : g_width_check
        $error("iopb_translator: only a 32-bit bus with a 16-bit processor is supported");
    end

    // byte lane enables from size and low address bits, lane 3 highest
    function automatic logic [3:0] lane_enables(input logic [1:0] size, input logic [1:0] a);
        logic [3:0] be;
        be = 4'h0;
        unique case (size)
            `IOPB_SIZE_BYTE:   be = 4'h8 >> a;
            `IOPB_SIZE_WORD:   be = a[1] ? 4'h3 : 4'hc;
            `IOPB_SIZE_TRIPLE: be = a[0] ? 4'h7 : 4'he;
            `IOPB_SIZE_LONG:   be = 4'hf;
        endcase
        return be;
    endfunction : lane_enables

    iopb_phase_t phase_r;
    iopb_phase_t phase_nxt;
    logic                 sack_r;
    logic                 sack_nxt;
    logic                 bus_error_handshake_r;
    logic                 bus_error_handshake_nxt;
    logic                 halt_r;
    logic                 halt_nxt;
    logic [AD_W-1:0]      ad_r;
    logic [AD_W-1:0]      ad_nxt;
    logic [IOP_DW-1:0]    rdata_r;
    logic [IOP_DW-1:0]    rdata_nxt;
    logic                 status_ok;
    logic                 status_bad;
    logic                 tenure_w;
    logic                 ack_w;
    logic [3:0]           par_gen;
    logic                 fault_w;

    iopb_arbiter u_arbiter (
        .core_clk              (core_clk),
        .sys_rst               (sys_rst),
        .top_address_bit       (iop_addr[AD_W-1]),
        .function_code_hi      (function_code_hi),
        .function_code_lo      (function_code_lo),
        .processor_addr_strobe (processor_addr_strobe),
        .bus_grant_in          (bus_grant_in),
        .bus_busy_line         (bus_busy_line),
        .bus_lock              (bus_lock),
        .retry_seen            (status_retry),
        .transaction_done      (transaction_done),
        .bus_error_seen        (bus_error_handshake_r),
        .bus_request_out       (bus_request_out),
        .bus_ack_out           (ack_w),
        .bus_tenure            (tenure_w)
    );

    if (PARITY_EN) begin : g_parity
        iopb_parity u_parity (
            .core_clk        (core_clk),
            .sys_rst         (sys_rst),
            .bus_word_driven (ad_r),
            .sys_ad_in       (sys_ad_in),
            .sys_par_in      (sys_par_in),
            .read_latch_en   (read_latch_en),
            .par_gen         (par_gen),
            .parity_fault    (fault_w)
        );
    end else begin : g_no_parity
        assign par_gen = `IOPB_RST_PAR;
        assign fault_w = 1'b0;
    end

    // a fault may only count once the cycle has been acknowledged
    assign status_bad = status_error_line || status_retry;
    assign status_ok  = status_eod && !status_wait && !status_bad;
    assign transaction_done = ack_w && !sys_rst
                              && (!processor_addr_strobe || status_bad);

    // phase sequencer
    always_comb begin
        phase_nxt = phase_r;
        unique case (phase_r)
            IOPB_IDLE: begin
                if (tenure_w && processor_addr_strobe) begin
                    phase_nxt = IOPB_ADDR;
                end
            end
            IOPB_ADDR: begin
                if (status_bad || !tenure_w) begin
                    phase_nxt = IOPB_WAIT;
                end else if (status_ok) begin
                    phase_nxt = IOPB_DATA;
                end
            end
            IOPB_DATA: begin
                if (status_ok || status_bad || !tenure_w) begin
                    phase_nxt = IOPB_WAIT;
                end
            end
            IOPB_WAIT: begin
                if (!tenure_w) begin
                    phase_nxt = IOPB_IDLE;
                end
            end
        endcase
        if (sys_rst) begin
            phase_nxt = IOPB_IDLE;
        end
    end

    always_ff @(posedge core_clk) begin
        phase_r <= phase_nxt;
    end

    assign address_phase_flag = (phase_r == IOPB_ADDR);
    assign data_phase_flag    = (phase_r == IOPB_DATA);

    // processor handshakes
    always_comb begin
        sack_nxt = processor_addr_strobe && !sys_rst
                   && (sack_r || (data_phase_flag && status_ok));
        halt_nxt = processor_addr_strobe && !sys_rst
                   && (halt_r || (ack_w && status_retry));
        bus_error_handshake_nxt = processor_addr_strobe && !sys_rst
                   && (bus_error_handshake_r
                       || (phase_r inside {IOPB_ADDR, IOPB_DATA} && status_bad)
                       || (sack_r && fault_w));
    end

    always_ff @(posedge core_clk) begin
        sack_r <= sack_nxt;
        halt_r <= halt_nxt;
        bus_error_handshake_r <= bus_error_handshake_nxt;
    end

    assign size_acknowledge    = sack_r && !bus_error_handshake_r;
    assign bus_error_handshake = bus_error_handshake_r;
    assign halt_handshake      = halt_r;

    // multiplexed address/data word, loaded with the phase it belongs to
    always_comb begin
        ad_nxt = ad_r;
        if (phase_nxt == IOPB_ADDR) begin
            ad_nxt = iop_addr;
        end else if (phase_nxt == IOPB_DATA && !iop_read) begin
            ad_nxt = {iop_wdata, iop_wdata};
        end
        if (sys_rst) begin
            ad_nxt = `IOPB_RST_DATA;
        end
    end

    always_ff @(posedge core_clk) begin
        ad_r <= ad_nxt;
    end

    assign sys_ad_out = ad_r;
    assign sys_ad_oe  = tenure_w && (address_phase_flag || (data_phase_flag && !iop_read));

    // read data: sampled on the edge, address bit 1 clear takes the upper half
    assign read_latch_en = data_phase_flag && iop_read;
    always_comb begin
        rdata_nxt = rdata_r;
        if (read_latch_en) begin
            rdata_nxt = iop_addr[1] ? sys_ad_in[IOP_DW-1:0] : sys_ad_in[AD_W-1:IOP_DW];
        end
        if (sys_rst) begin
            rdata_nxt = `IOPB_RST_HALF;
        end
    end

    always_ff @(posedge core_clk) begin
        rdata_r <= rdata_nxt;
    end

    assign iop_rdata    = rdata_r;
    assign iop_rdata_oe = processor_addr_strobe && iop_read && (read_latch_en || sack_r);

    // parity lines
    assign sys_par_out  = par_gen;
    assign sys_par_oe   = PARITY_EN && tenure_w
                          && (address_phase_flag || (data_phase_flag && !iop_read));
    assign parity_fault = fault_w;

    // control field, chosen by the phase flags, iop_read, iop_size and the low address bits
    always_comb begin
        ctrl_out = '0;
        ctrl_out[`IOPB_CTRL_ADDR_BIT] = address_phase_flag;
        ctrl_out[`IOPB_CTRL_DATA_BIT] = data_phase_flag;
        ctrl_out[`IOPB_CTRL_READ_BIT] = iop_read || !(address_phase_flag || data_phase_flag);
        if (data_phase_flag) begin
            ctrl_out[`IOPB_CTRL_BE_LSB +: `IOPB_CTRL_BE_W] = lane_enables(iop_size, iop_addr[1:0]);
        end
    end

    assign ctrl_par_out = (^ctrl_out) ^ `IOPB_PAR_ODD;
    assign ctrl_oe      = tenure_w;
    assign bus_ack_out  = ack_w;
    assign bus_tenure   = tenure_w;

endmodule : iopb_translator

`default_nettype wire

// ### tb/iopb_chk.sv
// iopb_chk: port-level assertions for the bus translator
// assumes binding into iopb_translator with the parity section fitted
`default_nettype none
module iopb_chk #(
    parameter int AD_W   = 32,
    parameter int IOP_DW = 16
) (
    input wire logic              core_clk,
    input wire logic              sys_rst,
    input wire logic [AD_W-1:0]   iop_addr,
    input wire logic [IOP_DW-1:0] iop_wdata,
    input wire logic              iop_read,
    input wire logic              function_code_lo,
    input wire logic              processor_addr_strobe,
    input wire logic              bus_request_out,
    input wire logic              bus_grant_in,
    input wire logic              bus_busy_line,
    input wire logic              bus_ack_out,
    input wire logic              bus_error_handshake,
    input wire logic              parity_fault,
    input wire logic [AD_W-1:0]   sys_ad_out,
    input wire logic              sys_ad_oe,
    input wire logic [3:0]        sys_par_out,
    input wire logic              sys_par_oe,
    input wire logic [6:0]        ctrl_out,
    input wire logic              ctrl_oe,
    input wire logic              address_phase_flag,
    input wire logic              data_phase_flag,
    input wire logic              read_latch_en,
    input wire logic              bus_tenure,
    input wire logic              transaction_done
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    logic [3:0] odd_par;
    assign odd_par = {~^sys_ad_out[31:24], ~^sys_ad_out[23:16], ~^sys_ad_out[15:8], ~^sys_ad_out[7:0]};
    chk_req_qual: assert property (bus_request_out |-> $past(processor_addr_strobe) && $past(iop_addr[31])
        && $past(function_code_lo))
        else $error("request without qualified access");
    chk_ack_grant: assert property (bus_grant_in && !bus_busy_line && !bus_ack_out |=> bus_ack_out)
        else $error("grant on free bus not acknowledged");
    chk_tenure_def: assert property (bus_tenure == (bus_ack_out && !transaction_done) && ctrl_oe == bus_tenure)
        else $error("tenure or control enable wrong");
    chk_phase_code: assert property (ctrl_out[1:0] == {data_phase_flag, address_phase_flag} && ctrl_out[1:0] != 2'h3)
        else $error("control phase code wrong");
    chk_first_addr: assert property ($rose(bus_tenure) |=> address_phase_flag)
        else $error("no address phase after tenure");
    chk_addr_drive: assert property (address_phase_flag |-> sys_ad_oe == bus_tenure && sys_ad_out == iop_addr)
        else $error("address not driven in address phase");
    chk_write_dup: assert property (data_phase_flag && !iop_read |-> sys_ad_oe == bus_tenure
        && sys_ad_out == {2{iop_wdata}})
        else $error("write data not duplicated");
    chk_par_oe: assert property (sys_par_oe == (bus_tenure && (address_phase_flag || (data_phase_flag && !iop_read))))
        else $error("parity enable wrong");
    chk_par_value: assert property (sys_par_oe |-> sys_par_out == odd_par)
        else $error("parity value wrong");
    chk_latch_en: assert property (read_latch_en == (data_phase_flag && iop_read) && !(sys_ad_oe && read_latch_en))
        else $error("read latch enable wrong");
    chk_late_bus_error_handshake: assert property (parity_fault && processor_addr_strobe |=> bus_error_handshake)
        else $error("parity fault without bus error");
endmodule : iopb_chk
bind iopb_translator iopb_chk #(.AD_W(AD_W), .IOP_DW(IOP_DW)) u_chk (
    .core_clk(core_clk), .sys_rst(sys_rst), .iop_addr(iop_addr), .iop_wdata(iop_wdata), .iop_read(iop_read),
    .function_code_lo(function_code_lo), .processor_addr_strobe(processor_addr_strobe),
    .bus_request_out(bus_request_out), .bus_grant_in(bus_grant_in), .bus_busy_line(bus_busy_line),
    .bus_ack_out(bus_ack_out), .bus_error_handshake(bus_error_handshake), .parity_fault(parity_fault),
    .sys_ad_out(sys_ad_out), .sys_ad_oe(sys_ad_oe), .sys_par_out(sys_par_out), .sys_par_oe(sys_par_oe),
    .ctrl_out(ctrl_out), .ctrl_oe(ctrl_oe), .address_phase_flag(address_phase_flag),
    .data_phase_flag(data_phase_flag), .read_latch_en(read_latch_en), .bus_tenure(bus_tenure),
    .transaction_done(transaction_done));
`default_nettype wire

// ### tb/iopb_sys_model.sv
// iopb_sys_model: system bus arbiter and slave facing the translator
// assumes ctrl_out bits 1:0 carry the phase and bit 2 the read flag
`default_nettype none
module iopb_sys_model (
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic        bus_request_out,
    input  wire logic        bus_ack_out,
    input  wire logic [6:0]  ctrl_out,
    input  wire logic [31:0] sys_ad_out,
    input  wire logic        sys_ad_oe,
    input  wire logic [3:0]  sys_par_out,
    input  wire logic        sys_par_oe,
    input  wire logic [31:0] slv_rdata,
    input  wire logic [7:0]  slv_wait,
    input  wire logic [1:0]  slv_resp,
    input  wire logic        slv_bad_par,
    output logic             bus_grant_in,
    output logic             status_eod,
    output logic             status_wait,
    output logic             status_retry,
    output logic             status_error_line,
    output logic      [31:0] sys_ad_in,
    output logic      [3:0]  sys_par_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0]  ph_r;
    logic [7:0]  cnt_r, cur;
    logic [31:0] ad_last_r;
    logic [3:0]  par_last_r, par_gen;
    logic        fin, slv_drv;
    always_comb begin
        cur = (ctrl_out[1:0] != ph_r) ? 8'h00 : cnt_r;
        fin = (|ctrl_out[1:0]) && cur >= slv_wait;
        slv_drv = ctrl_out[1] && ctrl_out[2];
        for (int i = 0; i < 4; i++) begin
            par_gen[i] = ~^slv_rdata[i*8 +: 8];
        end
    end
    // wait for slv_wait cycles in each phase, then answer
    assign status_wait       = (|ctrl_out[1:0]) && !fin;
    assign status_eod        = fin && slv_resp == 2'h0;
    assign status_error_line = fin && slv_resp == 2'h1;
    assign status_retry      = fin && slv_resp == 2'h2;
    // released lines show the inverse of their last value
    assign sys_ad_in  = sys_ad_oe ? sys_ad_out : slv_drv ? slv_rdata : ~ad_last_r;
    assign sys_par_in = sys_par_oe ? sys_par_out : slv_drv ? par_gen ^ {3'h0, slv_bad_par} : ~par_last_r;
    always_ff @(posedge core_clk) begin
        ph_r <= ctrl_out[1:0];
        cnt_r <= cur + 8'h01;
        ad_last_r <= sys_ad_in;
        par_last_r <= sys_par_in;
        bus_grant_in <= !sys_rst && bus_request_out && !bus_ack_out;
    end
endmodule : iopb_sys_model
`default_nettype wire

// ### tb/iopb_translator_bench.sv
// iopb_translator_bench: self-checking bench for the bus translator
// assumes iopb_sys_model as far side and iopb_chk bound in
`default_nettype none
module iopb_translator_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk = 1'b0, sys_rst = 1'b1, iop_read = 1'b0, function_code_hi = 1'b0;
    logic        function_code_lo = 1'b0, processor_addr_strobe = 1'b0, bus_busy_line = 1'b0, bus_lock = 1'b0;
    logic        slv_bad_par = 1'b0, saw_req = 1'b0, saw_pf = 1'b0;
    logic [31:0] iop_addr = 32'h0, sys_ad_in, sys_ad_out, slv_rdata = 32'h1234_abcd;
    logic [15:0] iop_wdata = 16'h0, iop_rdata;
    logic [7:0]  slv_wait = 8'h0;
    logic [1:0]  iop_size = 2'h2, slv_resp = 2'h0;
    logic [6:0]  ctrl_out;
    logic [3:0]  sys_par_in, sys_par_out;
    logic iop_rdata_oe, size_acknowledge, bus_error_handshake, halt_handshake, bus_request_out, bus_grant_in;
    logic bus_ack_out, status_eod, status_wait, status_retry, status_error_line, sys_ad_oe, sys_par_oe;
    logic ctrl_par_out, ctrl_oe, address_phase_flag, data_phase_flag, read_latch_en, bus_tenure;
    logic transaction_done, parity_fault;
    int error_cnt = 0;
    int checks_done = 0;
    iopb_translator dut (.core_clk(core_clk), .sys_rst(sys_rst), .iop_addr(iop_addr), .iop_wdata(iop_wdata),
        .iop_read(iop_read), .iop_size(iop_size), .function_code_hi(function_code_hi),
        .function_code_lo(function_code_lo), .processor_addr_strobe(processor_addr_strobe),
        .iop_rdata(iop_rdata), .iop_rdata_oe(iop_rdata_oe), .size_acknowledge(size_acknowledge),
        .bus_error_handshake(bus_error_handshake), .halt_handshake(halt_handshake),
        .bus_request_out(bus_request_out), .bus_grant_in(bus_grant_in), .bus_busy_line(bus_busy_line),
        .bus_lock(bus_lock), .bus_ack_out(bus_ack_out), .status_eod(status_eod), .status_wait(status_wait),
        .status_retry(status_retry), .status_error_line(status_error_line), .sys_ad_in(sys_ad_in),
        .sys_ad_out(sys_ad_out), .sys_ad_oe(sys_ad_oe), .sys_par_in(sys_par_in), .sys_par_out(sys_par_out),
        .sys_par_oe(sys_par_oe), .ctrl_out(ctrl_out), .ctrl_par_out(ctrl_par_out), .ctrl_oe(ctrl_oe),
        .address_phase_flag(address_phase_flag), .data_phase_flag(data_phase_flag),
        .read_latch_en(read_latch_en), .bus_tenure(bus_tenure), .transaction_done(transaction_done),
        .parity_fault(parity_fault));
    iopb_sys_model far (.core_clk(core_clk), .sys_rst(sys_rst), .bus_request_out(bus_request_out),
        .bus_ack_out(bus_ack_out), .ctrl_out(ctrl_out), .sys_ad_out(sys_ad_out), .sys_ad_oe(sys_ad_oe),
        .sys_par_out(sys_par_out), .sys_par_oe(sys_par_oe), .slv_rdata(slv_rdata), .slv_wait(slv_wait),
        .slv_resp(slv_resp), .slv_bad_par(slv_bad_par), .bus_grant_in(bus_grant_in), .status_eod(status_eod),
        .status_wait(status_wait), .status_retry(status_retry), .status_error_line(status_error_line),
        .sys_ad_in(sys_ad_in), .sys_par_in(sys_par_in));
    always #20 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        if (bus_request_out === 1'b1) saw_req <= 1'b1;
        if (parity_fault === 1'b1) saw_pf <= 1'b1;
    end
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic tally_and_finish;
        if (error_cnt == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : tally_and_finish
    // one processor cycle; handshakes are gathered over four cycles to catch a late error
    task automatic run_cycle(input logic [31:0] a, input logic rd, input logic [7:0] wt, input logic [1:0] rs,
        input logic bad, output logic [2:0] hs, output logic [15:0] rdv);
        hs = 3'h0;
        rdv = 16'h0;
        saw_req = 1'b0;
        saw_pf = 1'b0;
        slv_wait = wt;
        slv_resp = rs;
        slv_bad_par = bad;
        iop_addr = a;
        iop_read = rd;
        iop_wdata = 16'h5aa5;
        function_code_lo = 1'b1;
        processor_addr_strobe = 1'b1;
        while (size_acknowledge !== 1'b1 && bus_error_handshake !== 1'b1) @(negedge core_clk);
        rdv = iop_rdata;
        check("rdata enable", iop_rdata_oe, rd);
        check("ctrl parity", ctrl_par_out, ~^ctrl_out);
        repeat (4) begin
            hs = hs | {size_acknowledge, bus_error_handshake, halt_handshake};
            @(negedge core_clk);
        end
        processor_addr_strobe = 1'b0;
        repeat (3) @(negedge core_clk);
        check("tenure after strobe", {bus_ack_out, bus_tenure}, 32'h0);
    endtask : run_cycle
    task automatic t_write;
        logic [2:0] hs;
        logic [15:0] rdv;
        run_cycle(32'h8000_0010, 1'b0, 8'h2, 2'h0, 1'b0, hs, rdv);
        check("write request", saw_req, 32'h1);
        check("write handshakes", hs, 32'h4);
    endtask : t_write
    task automatic t_read;
        logic [2:0] hs;
        logic [15:0] rdv;
        for (int i = 0; i < 2; i++) begin
            run_cycle(32'h8000_0100 | (i << 1), 1'b1, 8'h1, 2'h0, 1'b0, hs, rdv);
            check("read half", rdv, i ? 32'habcd : 32'h1234);
            check("read handshakes", hs, 32'h4);
        end
        run_cycle(32'h8000_0200, 1'b1, 8'h0, 2'h0, 1'b1, hs, rdv);
        check("parity fault", saw_pf, 32'h1);
        check("late bus error", hs, 32'h6);
    endtask : t_read
    task automatic t_status;
        logic [2:0] hs;
        logic [15:0] rdv;
        for (int r = 1; r < 3; r++) begin
            run_cycle(32'h8000_0300, 1'b0, 8'h1, r[1:0], 1'b0, hs, rdv);
            check("error handshakes", hs, r == 2 ? 32'h3 : 32'h2);
        end
    endtask : t_status
    task automatic t_noreq;
        saw_req = 1'b0;
        iop_addr = 32'h0000_0010;
        function_code_lo = 1'b1;
        processor_addr_strobe = 1'b1;
        repeat (4) @(negedge core_clk);
        iop_addr = 32'h8000_0010;
        function_code_hi = 1'b1;
        repeat (4) @(negedge core_clk);
        processor_addr_strobe = 1'b0;
        function_code_hi = 1'b0;
        repeat (2) @(negedge core_clk);
        check("unqualified request", saw_req, 32'h0);
    endtask : t_noreq
    task automatic t_busy;
        bus_busy_line = 1'b1;
        iop_addr = 32'h8000_0020;
        iop_read = 1'b0;
        processor_addr_strobe = 1'b1;
        repeat (6) @(negedge core_clk);
        check("ack while busy", bus_ack_out, 32'h0);
        bus_busy_line = 1'b0;
        repeat (3) @(negedge core_clk);
        check("ack once free", bus_ack_out, 32'h1);
        repeat (6) @(negedge core_clk);
        processor_addr_strobe = 1'b0;
        repeat (3) @(negedge core_clk);
    endtask : t_busy
    initial begin
        repeat (11) @(negedge core_clk);
        check("reset outputs", {bus_request_out, bus_ack_out, bus_tenure, address_phase_flag, data_phase_flag,
            size_acknowledge, bus_error_handshake, halt_handshake}, 32'h0);
        @(negedge core_clk);
        sys_rst = 1'b0;
        @(negedge core_clk);
        t_write();
        t_read();
        t_status();
        t_noreq();
        t_busy();
        tally_and_finish();
    end
    // the whole sequence needs under two hundred cycles
    initial begin
        #200000;
        error_cnt++;
        tally_and_finish();
    end
endmodule : iopb_translator_bench
`default_nettype wire
